//--- core/stu_consts.vh
// Constants for the standard timer unit
`ifndef STU_CONSTS_VH
`define STU_CONSTS_VH
// Register offsets
`define STU_ADR_CTL0 3'h0
`define STU_ADR_CTL1 3'h1
`define STU_ADR_CNTL 3'h2
`define STU_ADR_CNTH 3'h3
`define STU_ADR_CMPL 3'h4
`define STU_ADR_CMPH 3'h5
`define STU_ADR_ISTS 3'h6
`define STU_ADR_IEN 3'h7
// Control field positions
`define STU_C0_PAUSE 7
`define STU_C0_CKS_HI 6
`define STU_C0_CKS_LO 4
`define STU_C0_ON 3
`define STU_C0_CP_HI 2
`define STU_C0_CP_LO 0
`define STU_C1_MD_HI 7
`define STU_C1_MD_LO 6
`define STU_C1_FN_HI 5
`define STU_C1_FN_LO 4
`define STU_C1_OC 3
`define STU_C1_POL 2
`define STU_C1_DPX 1
`define STU_C1_CCLR 0
// Operating modes
`define STU_MD_CMP 2'h0
`define STU_MD_CAP 2'h1
`define STU_MD_PWM 2'h2
`define STU_MD_TMR 2'h3
// Clock selects
`define STU_CK_SYS4 3'h0
`define STU_CK_SYS 3'h1
`define STU_CK_H16 3'h2
`define STU_CK_H64 3'h3
`define STU_CK_SUB0 3'h4
`define STU_CK_SUB1 3'h5
`define STU_CK_EXTR 3'h6
`define STU_CK_EXTF 3'h7
// Prescaler terminal counts
`define STU_DIV4_TC 6'h03
`define STU_DIV16_TC 6'h0f
`define STU_DIV64_TC 6'h3f
// Reset values, count increment and zero P select
`define STU_BYTE_RST 8'h00
`define STU_CNT_RST 10'h000
`define STU_CNT_ONE 10'h001
`define STU_CP_ZERO 3'h0
`define STU_IRQ_RST 2'h0
// Interrupt bits
`define STU_IRQ_A 0
`define STU_IRQ_P 1
`endif

//--- core/stu_timer.v
// Standard timer unit: counter, comparators, pin logic and register port
// ============================================================
// Notes on behaviour
// - Free-running up-counter, equality means match
// - Match raises interrupt, may clear counter, pin
// - Separate interrupts for comparator A and P
// - Three-bit select picks counter clock source
// - External pin counts on chosen edge
// - External pin triggers single pulse
// - Capture on rising, falling or both edges
// - Compare match sets, clears or toggles pin
// - PWM leaves on the timer output pin
// - Edge PWM, duty or period adjustable
// - Low bytes only via shared 8-bit buffer
// - Low write buffers; high write commits both
// - High read snapshots low byte into buffer
// - Clock select decode table
// - 10-bit counter, P checks top three bits
// - On-bit rise clears counter, fall holds
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "stu_consts.vh"
`default_nettype none
module stu_timer #(
    parameter CNT_W = 10,
    parameter CP_W = 3
) (
    input wire core_clk_in,
    input wire rst_n_in,
    input wire [2:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [7:0] reg_rdata_out,
    input wire high_clk_tick_in,
    input wire sub_clk_tick_in,
    input wire ext_count_clock_pin_in,
    input wire capture_input_pin_in,
    output reg timer_output_pin_out,
    output reg irq_out
);
    // ============================================================
    // Registers
    reg [7:0] ctl0_r;
    reg [7:0] ctl1_r;
    reg [7:0] lowbuf_r;
    reg [CNT_W-1:0] cmpa_r;
    reg [CNT_W-1:0] cnt_r;
    reg [1:0] ists_r;
    reg [1:0] ien_r;
    reg [5:0] pre_sys_r;
    reg [5:0] pre_h_r;
    reg on_d_r;
    reg [2:0] ck_sync_r;
    reg [2:0] cap_sync_r;
    reg ck_lvl_r;
    reg cap_lvl_r;
    reg pulse_run_r;

    wire [2:0] ck_sel = ctl0_r[`STU_C0_CKS_HI:`STU_C0_CKS_LO];
    wire [CP_W-1:0] cp_val = ctl0_r[`STU_C0_CP_HI:`STU_C0_CP_LO];
    wire on_bit = ctl0_r[`STU_C0_ON];
    wire pause_bit = ctl0_r[`STU_C0_PAUSE];
    wire [1:0] mode = ctl1_r[`STU_C1_MD_HI:`STU_C1_MD_LO];
    wire [1:0] fn = ctl1_r[`STU_C1_FN_HI:`STU_C1_FN_LO];
    wire init_lvl = ctl1_r[`STU_C1_OC];
    wire pol = ctl1_r[`STU_C1_POL];
    wire dpx = ctl1_r[`STU_C1_DPX];
    wire cclr = ctl1_r[`STU_C1_CCLR];

    // ============================================================
    // Pin synchronisers; a level change counts once stages 2 and 3 agree
    wire ck_agree = (ck_sync_r[1] == ck_sync_r[2]);
    wire cap_agree = (cap_sync_r[1] == cap_sync_r[2]);
    wire ck_rise = ck_agree && ck_sync_r[2] && !ck_lvl_r;
    wire ck_fall = ck_agree && !ck_sync_r[2] && ck_lvl_r;
    wire cap_rise = cap_agree && cap_sync_r[2] && !cap_lvl_r;
    wire cap_fall = cap_agree && !cap_sync_r[2] && cap_lvl_r;

    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ck_sync_r <= 3'h0;
            cap_sync_r <= 3'h0;
            ck_lvl_r <= 1'b0;
            cap_lvl_r <= 1'b0;
        end
        else
        begin
            ck_sync_r <= {ck_sync_r[1:0], ext_count_clock_pin_in};
            cap_sync_r <= {cap_sync_r[1:0], capture_input_pin_in};
            if (ck_agree)
                ck_lvl_r <= ck_sync_r[2];
            if (cap_agree)
                cap_lvl_r <= cap_sync_r[2];
        end
    end

    // ============================================================
    // Clock source select
    wire sys4_tick = ({4'h0, pre_sys_r[1:0]} == `STU_DIV4_TC);
    reg cnt_tick;
    always @*
    begin
        case (ck_sel)
            `STU_CK_SYS4: cnt_tick = sys4_tick;
            `STU_CK_SYS: cnt_tick = 1'b1;
            `STU_CK_H16: cnt_tick = high_clk_tick_in && ({2'h0, pre_h_r[3:0]} == `STU_DIV16_TC);
            `STU_CK_H64: cnt_tick = high_clk_tick_in && (pre_h_r == `STU_DIV64_TC);
            `STU_CK_SUB0: cnt_tick = sub_clk_tick_in;
            `STU_CK_SUB1: cnt_tick = sub_clk_tick_in;
            `STU_CK_EXTR: cnt_tick = ck_rise;
            `STU_CK_EXTF: cnt_tick = ck_fall;
            default: cnt_tick = 1'b0;
        endcase
    end

    // ============================================================
    // Comparators and counter
    // Single pulse waits for a trigger; other modes run whenever on and not paused
    wire sp_mode = (mode == `STU_MD_PWM) && (fn == 2'h3);
    wire trig = (ck_sel == `STU_CK_EXTF) ? ck_fall : ck_rise;
    wire run = on_bit && !pause_bit && (!sp_mode || pulse_run_r);
    wire match_a = run && cnt_tick && (cnt_r == cmpa_r);
    wire p_hit = (cp_val == `STU_CP_ZERO) ? (cnt_r == {CNT_W{1'b1}})
                                          : (cnt_r[CNT_W-1:CNT_W-CP_W] == cp_val
                                             && cnt_r[CNT_W-CP_W-1:0] == {(CNT_W-CP_W){1'b0}});
    wire match_p = run && cnt_tick && p_hit;
    wire on_rise = on_bit && !on_d_r;
    // PWM: dpx=0 period from P, duty from A; dpx=1 swapped roles
    wire pwm_mode = (mode == `STU_MD_PWM);
    wire clr_evt = (pwm_mode && !sp_mode) ? (dpx ? match_a : match_p)
                                          : (cclr ? match_a : match_p);

    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cnt_r <= `STU_CNT_RST;
            pre_sys_r <= 6'h00;
            pre_h_r <= 6'h00;
            on_d_r <= 1'b0;
            pulse_run_r <= 1'b0;
        end
        else
        begin
            pre_sys_r <= pre_sys_r + 6'h01;
            if (high_clk_tick_in)
                pre_h_r <= pre_h_r + 6'h01;
            on_d_r <= on_bit;
            if (on_rise)
                cnt_r <= `STU_CNT_RST;
            else if (clr_evt)
                cnt_r <= `STU_CNT_RST;
            else if (run && cnt_tick)
                cnt_r <= cnt_r + `STU_CNT_ONE;
            if (!on_bit || on_rise || !sp_mode)
                pulse_run_r <= 1'b0;
            else if (trig)
                pulse_run_r <= 1'b1;
            else if (match_a)
                pulse_run_r <= 1'b0;
        end
    end

    // ============================================================
    // Output pin
    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            timer_output_pin_out <= 1'b0;
        else if (on_rise || !on_bit && mode != `STU_MD_CMP)
            timer_output_pin_out <= (pwm_mode ? !pol : init_lvl);
        else if (mode == `STU_MD_CMP && match_a)
        begin
            case (fn)
                2'h1: timer_output_pin_out <= 1'b0;
                2'h2: timer_output_pin_out <= 1'b1;
                2'h3: timer_output_pin_out <= !timer_output_pin_out;
                default: timer_output_pin_out <= timer_output_pin_out;
            endcase
        end
        else if (pwm_mode)
        begin
            case (fn)
                2'h0: timer_output_pin_out <= !pol;
                2'h1: timer_output_pin_out <= pol;
                2'h2: timer_output_pin_out <= (dpx ? !p_hit && cnt_r[CNT_W-1:CNT_W-CP_W] < cp_val
                                                   : cnt_r < cmpa_r) ? pol : !pol;
                default: timer_output_pin_out <= pulse_run_r ? pol : !pol;
            endcase
        end
    end

    // ============================================================
    // Capture: the counter value lands in compare A
    wire cap_evt = on_bit && mode == `STU_MD_CAP &&
                   ((fn == 2'h0 && cap_rise) || (fn == 2'h1 && cap_fall) ||
                    (fn == 2'h2 && (cap_rise || cap_fall)));

    // ============================================================
    // Register port; low bytes pass through one shared buffer
    wire [7:0] cnt_hi = {{(16-CNT_W){1'b0}}, cnt_r[CNT_W-1:8]};
    wire [7:0] cmp_hi = {{(16-CNT_W){1'b0}}, cmpa_r[CNT_W-1:8]};
    // Capture mode reuses compare A as the capture store, so only captures flag there
    wire [1:0] ev = {match_p, (match_a && mode != `STU_MD_CAP) || cap_evt};
    wire wr_clr = reg_wr_in && reg_addr_in == `STU_ADR_ISTS;

    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ctl0_r <= `STU_BYTE_RST;
            ctl1_r <= `STU_BYTE_RST;
            lowbuf_r <= `STU_BYTE_RST;
            cmpa_r <= `STU_CNT_RST;
            ists_r <= `STU_IRQ_RST;
            ien_r <= `STU_IRQ_RST;
            reg_rdata_out <= `STU_BYTE_RST;
            irq_out <= 1'b0;
        end
        else
        begin
            // Set beats clear in the same cycle
            ists_r <= (ists_r & ~(wr_clr ? reg_wdata_in[1:0] : 2'h0)) | ev;
            irq_out <= |(ists_r & ien_r);
            if (cap_evt)
                cmpa_r <= cnt_r;
            if (reg_wr_in)
            begin
                case (reg_addr_in)
                    `STU_ADR_CTL0: ctl0_r <= reg_wdata_in;
                    `STU_ADR_CTL1: ctl1_r <= reg_wdata_in;
                    `STU_ADR_CMPL: lowbuf_r <= reg_wdata_in;
                    `STU_ADR_CMPH: if (!cap_evt)
                        cmpa_r <= {reg_wdata_in[CNT_W-9:0], lowbuf_r};
                    `STU_ADR_IEN: ien_r <= reg_wdata_in[1:0];
                    default: ;
                endcase
            end
            reg_rdata_out <= `STU_BYTE_RST;
            if (reg_rd_in)
            begin
                case (reg_addr_in)
                    `STU_ADR_CTL0: reg_rdata_out <= ctl0_r;
                    `STU_ADR_CTL1: reg_rdata_out <= ctl1_r;
                    `STU_ADR_CNTL: reg_rdata_out <= lowbuf_r;
                    `STU_ADR_CMPL: reg_rdata_out <= lowbuf_r;
                    `STU_ADR_CNTH:
                    begin
                        reg_rdata_out <= cnt_hi;
                        lowbuf_r <= cnt_r[7:0];
                    end
                    `STU_ADR_CMPH:
                    begin
                        reg_rdata_out <= cmp_hi;
                        lowbuf_r <= cmpa_r[7:0];
                    end
                    `STU_ADR_ISTS: reg_rdata_out <= {6'h00, ists_r};
                    `STU_ADR_IEN: reg_rdata_out <= {6'h00, ien_r};
                    default: reg_rdata_out <= `STU_BYTE_RST;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/stu_timer_monitor.sv
// Checker for the standard timer unit ports
`timescale 1ns/100ps
`default_nettype none
module stu_timer_monitor (
    input wire core_clk_in,
    input wire rst_n_in,
    input wire [2:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_rdata_out,
    input wire timer_output_pin_out,
    input wire irq_out
);
    // ============================================================
    // Shadow of software writes
    reg [7:0] ctl0_r;
    reg [1:0] en_r;
    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ctl0_r <= 8'h00;
            en_r <= 2'h0;
        end
        else if (reg_wr_in && reg_addr_in == 3'h0)
            ctl0_r <= reg_wdata_in;
        else if (reg_wr_in && reg_addr_in == 3'h7)
            en_r <= reg_wdata_in[1:0];
    end
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    // ============================================================
    // Port relations
    idle_data_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("read data not idle");
    ctl_back_a: assert property ($past(reg_rd_in && reg_addr_in == 3'h0) |-> reg_rdata_out == $past(ctl0_r))
        else $error("control readback");
    en_back_a: assert property ($past(reg_rd_in && reg_addr_in == 3'h7) |-> reg_rdata_out[1:0] == $past(en_r))
        else $error("enable readback");
    high_width_a: assert property ($past(reg_rd_in && (reg_addr_in == 3'h3 || reg_addr_in == 3'h5))
        |-> reg_rdata_out[7:2] == 6'h00)
        else $error("high byte too wide");
    cnt_clear_a: assert property ((reg_wr_in && reg_addr_in == 3'h0 && reg_wdata_in[3] && !ctl0_r[3])
        ##2 (reg_rd_in && reg_addr_in == 3'h3) |=> reg_rdata_out == 8'h00)
        else $error("counter not cleared");
    irq_mask_a: assert property ((reg_wr_in && reg_addr_in == 3'h7 && reg_wdata_in[1:0] == 2'h0) |-> ##2 !irq_out)
        else $error("masked irq high");
    irq_cause_a: assert property (irq_out |-> $past(en_r) != 2'h0)
        else $error("irq without enable");
    sts_clear_a: assert property ((reg_wr_in && reg_addr_in == 3'h6 && reg_wdata_in[1:0] == 2'h3 && !ctl0_r[3])
        ##2 (reg_rd_in && reg_addr_in == 3'h6) |=> reg_rdata_out[1:0] == 2'h0)
        else $error("status not cleared");
endmodule
bind stu_timer stu_timer_monitor stu_timer_monitor_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .timer_output_pin_out(timer_output_pin_out), .irq_out(irq_out));
`default_nettype wire

//--- tb/stu_pins_model.sv
// Far-side pin driver for the standard timer unit
`timescale 1ns/100ps
`default_nettype none
module stu_pins_model (
    input wire core_clk_in,
    output logic ext_count_clock_pin_out,
    output logic capture_input_pin_out
);
    initial
    begin
        ext_count_clock_pin_out = 1'b0;
        capture_input_pin_out = 1'b0;
    end
    // Levels held 4 cycles so the synchroniser sees each edge once
    task automatic ext_pulses(input int n);
        repeat (n)
        begin
            repeat (4) @(posedge core_clk_in);
            ext_count_clock_pin_out <= 1'b1;
            repeat (4) @(posedge core_clk_in);
            ext_count_clock_pin_out <= 1'b0;
        end
        repeat (6) @(posedge core_clk_in);
    endtask
    task automatic cap_toggle();
        @(posedge core_clk_in);
        capture_input_pin_out <= ~capture_input_pin_out;
        repeat (8) @(posedge core_clk_in);
    endtask
endmodule
`default_nettype wire

//--- tb/stu_timer_test.sv
// Self-checking bench for the standard timer unit
`timescale 1ns/100ps
`default_nettype none
module stu_timer_test;
    logic core_clk_in, rst_n_in, reg_wr_in, reg_rd_in, high_clk_tick_in;
    logic [2:0] reg_addr_in;
    logic [7:0] reg_wdata_in, b;
    logic [9:0] v, exp_cnt;
    wire [7:0] reg_rdata_out;
    wire timer_output_pin_out, irq_out, ext_pin, cap_pin;
    int error_cnt, checks;
    stu_timer stu_timer_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .high_clk_tick_in(high_clk_tick_in), .sub_clk_tick_in(1'b0), .ext_count_clock_pin_in(ext_pin),
        .capture_input_pin_in(cap_pin), .timer_output_pin_out(timer_output_pin_out), .irq_out(irq_out));
    // Pins assumed routed to the timer before use
    stu_pins_model stu_pins_model_i (.core_clk_in(core_clk_in), .ext_count_clock_pin_out(ext_pin),
        .capture_input_pin_out(cap_pin));
    initial
    begin
        core_clk_in = 1'b0;
        forever #20 core_clk_in = ~core_clk_in;
    end
    always @(posedge core_clk_in)
        high_clk_tick_in <= ~high_clk_tick_in;
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        #1;
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One access; read data lands in b
    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_wr_in <= w;
        reg_rd_in <= !w;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        #1;
        b = reg_rdata_out;
    endtask
    // High byte first, then low byte from the buffer
    task automatic rd10(input logic [2:0] hi);
        bus(1'b0, hi, 8'h00);
        v[9:8] = b[1:0];
        bus(1'b0, hi - 3'h1, 8'h00);
        v[7:0] = b;
    endtask
    task automatic close_out();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #200000;
        error_cnt++;
        close_out();
    end
    initial
    begin
        {rst_n_in, reg_wr_in, reg_rd_in, high_clk_tick_in, reg_addr_in, reg_wdata_in} = 15'h0000;
        {error_cnt, checks} = 64'h0;
        repeat (20) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b0, 3'(i), 8'h00);
            chk({2'h0, b}, 10'h000);
        end
        $display("reset values done");
        bus(1'b1, 3'h4, 8'ha5);
        bus(1'b1, 3'h5, 8'h02);
        bus(1'b1, 3'h4, 8'h3c);
        rd10(3'h5);
        chk(v, 10'h2a5);
        $display("byte buffer done");
        bus(1'b1, 3'h0, 8'h68);
        stu_pins_model_i.ext_pulses(5);
        bus(1'b1, 3'h0, 8'h60);
        stu_pins_model_i.ext_pulses(2);
        rd10(3'h3);
        chk(v, 10'h005);
        bus(1'b1, 3'h0, 8'h70);
        bus(1'b1, 3'h0, 8'h78);
        rd10(3'h3);
        chk(v, 10'h000);
        stu_pins_model_i.ext_pulses(3);
        rd10(3'h3);
        chk(v, 10'h003);
        $display("event counting done");
        bus(1'b1, 3'h0, 8'h70);
        bus(1'b1, 3'h1, 8'h40);
        bus(1'b1, 3'h0, 8'h78);
        exp_cnt = 10'h000;
        for (int fn = 0; fn < 4; fn++)
        begin
            bus(1'b1, 3'h1, 8'h40 | 8'(fn << 4));
            bus(1'b1, 3'h6, 8'h03);
            stu_pins_model_i.ext_pulses(fn + 1);
            exp_cnt = exp_cnt + 10'(fn + 1);
            stu_pins_model_i.cap_toggle();
            bus(1'b0, 3'h6, 8'h00);
            chk({9'h000, b[0]}, {9'h000, fn != 3});
            rd10(3'h5);
            chk(v, (fn != 3) ? exp_cnt : exp_cnt - 10'h004);
        end
        $display("capture done");
        bus(1'b1, 3'h0, 8'h11);
        bus(1'b1, 3'h1, 8'h30);
        bus(1'b1, 3'h4, 8'h0a);
        bus(1'b1, 3'h5, 8'h00);
        bus(1'b1, 3'h6, 8'h03);
        bus(1'b1, 3'h7, 8'h01);
        bus(1'b1, 3'h0, 8'h19);
        repeat (30) @(posedge core_clk_in);
        chk({8'h00, timer_output_pin_out, irq_out}, 10'h003);
        bus(1'b1, 3'h7, 8'h00);
        repeat (2) @(posedge core_clk_in);
        chk({9'h000, irq_out}, 10'h000);
        bus(1'b1, 3'h7, 8'h01);
        repeat (2) @(posedge core_clk_in);
        chk({9'h000, irq_out}, 10'h001);
        bus(1'b1, 3'h0, 8'h11);
        bus(1'b1, 3'h6, 8'h03);
        bus(1'b0, 3'h6, 8'h00);
        chk({1'b0, irq_out, b}, 10'h000);
        bus(1'b1, 3'h0, 8'h19);
        repeat (2) @(posedge core_clk_in);
        chk({9'h000, timer_output_pin_out}, 10'h000);
        repeat (140) @(posedge core_clk_in);
        bus(1'b0, 3'h6, 8'h00);
        chk({2'h0, b}, 10'h003);
        $display("compare match done");
        close_out();
    end
endmodule
`default_nettype wire
